// File: design/pgpio_defs.vh
// register map, field layout and timing constants for the pin config block
`ifndef PGPIO_DEFS_VH
`define PGPIO_DEFS_VH

// register addresses on the host register port
`define PG_ADDR_CFG6   8'h76
`define PG_ADDR_CFG7   8'h77
`define PG_ADDR_PUE    8'h78
`define PG_ADDR_PDE    8'h79
`define PG_ADDR_PEND   8'hF0

// reset values
`define PG_CFG6_RST    8'h00
`define PG_CFG7_RST    8'h00
`define PG_PUE_RST     8'h00
`define PG_PDE_RST     8'h00
`define PG_PEND_RST    2'h0

// per-pin config fields
`define PG_FLT_HI      7
`define PG_FLT_LO      6
`define PG_IRQ_RISE    5
`define PG_IRQ_FALL    4
`define PG_LVL         3
`define PG_SMP         2
`define PG_DIR         1
`define PG_DRV         0

// field encodings
`define PG_FLT_NONE    2'h0
`define PG_FLT_8MS     2'h1
`define PG_FLT_16MS    2'h2
`define PG_FLT_32MS    2'h3
`define PG_DIR_IN      1'h1
`define PG_DRV_PP      1'h1

// first pin of this block inside the shared pull registers
`define PG_PIN_BASE    6

// timing
`define PG_CLK_HZ      20000000
`define PG_MS_PER_S    1000
`define PG_FLT8_MS     8
`define PG_FLT16_MS    16
`define PG_FLT32_MS    32

`endif

// File: design/pgpio_filter.v
// input debounce filter for one general pin
`default_nettype none
`include "pgpio_defs.vh"

module pgpio_filter #(
  parameter integer CW  = 20,     // counter width
  parameter integer T8  = 160000, // cycles for the 8 ms setting
  parameter integer T16 = 320000, // cycles for the 16 ms setting
  parameter integer T32 = 640000  // cycles for the 32 ms setting
) (
  input  wire       clk_sys_i,
  input  wire       arst_n_i,
  input  wire       ce_i,
  input  wire       level_i,
  input  wire [1:0] sel_i,
  output wire       level_o
);

  // limits held one below the time, the counter starts at zero;
  // worked out at full width, then cut to the counter width
  localparam integer  M8  = T8 - 1;
  localparam integer  M16 = T16 - 1;
  localparam integer  M32 = T32 - 1;
  localparam [CW-1:0] L8  = M8[CW-1:0];
  localparam [CW-1:0] L16 = M16[CW-1:0];
  localparam [CW-1:0] L32 = M32[CW-1:0];

  reg [CW-1:0] cnt_q;   // cycles the new level has held
  reg          lvl_q;   // accepted level
  reg [CW-1:0] lim;     // limit for the selected time

  // pick the limit for the chosen time
  always @* begin
    case (sel_i)
      `PG_FLT_8MS:  lim = L8;
      `PG_FLT_16MS: lim = L16;
      default:      lim = L32;
    endcase
  end

  // level must hold unchanged for the full time, both edges alike
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= {CW{1'h0}};
      lvl_q <= 1'h0;
    end else if (ce_i) begin
      if (sel_i == `PG_FLT_NONE) begin
        // no filtering: follow the pin directly
        lvl_q <= level_i;
        cnt_q <= {CW{1'h0}};
      end else if (level_i == lvl_q) begin
        // bounce back: restart the wait
        cnt_q <= {CW{1'h0}};
      end else if (cnt_q >= lim) begin
        lvl_q <= level_i;
        cnt_q <= {CW{1'h0}};
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'h0}}, 1'h1};
      end
    end
  end

  assign level_o = lvl_q;

endmodule

`default_nettype wire

// File: design/pgpio_pin_cfg.v
// configuration, drive and event logic for general pins six and seven
//
// Overview of operation
// - input pins debounce both edges, 0/8/16/32 ms
// - output pins ignore the debounce field
// - edge field picks falling, rising or both
// - edge field zero masks all pin events
// - output pins ignore the edge field
// - output drives level bit, open-drain releases high
// - input: writing level 0 sets pull-up
// - input: writing level 1 sets pull-down
// - input pins show sampled level in bit 2
// - sampled-level bit ignores writes while input
// - direction bit: 0 output, 1 input
// - sequencer alternate output driven active-high always
// - alternate input polarity follows direction bit
// - drive bit: 0 open-drain, 1 push-pull
// - input pins ignore the drive bit
// - shared pull-up register enables each pull-up
// - shared pull-down register enables each pull-down
// - alternate enable overrides normal pin use
`default_nettype none
`include "pgpio_defs.vh"

module pgpio_pin_cfg #(
  parameter integer NPIN = 2,   // pins handled here
  parameter integer CW   = 20,  // debounce counter width
  // debounce lengths in cycles, shorten these for simulation
  parameter integer FLT8_CYC  =
    `PG_FLT8_MS * (`PG_CLK_HZ / `PG_MS_PER_S),
  parameter integer FLT16_CYC =
    `PG_FLT16_MS * (`PG_CLK_HZ / `PG_MS_PER_S),
  parameter integer FLT32_CYC =
    `PG_FLT32_MS * (`PG_CLK_HZ / `PG_MS_PER_S)
) (
  input  wire       clk_sys_i,     // system clock, 20 MHz
  input  wire       arst_n_i,      // async reset, active low
  input  wire       ce_i,          // clock enable, freezes all
  input  wire [7:0] reg_addr_i,    // register address
  input  wire       reg_wr_i,      // write strobe
  input  wire       reg_rd_i,      // read strobe
  input  wire [7:0] reg_wdata_i,   // write data
  output wire [7:0] reg_rdata_o,   // read data
  output wire       reg_rvalid_o,  // read data valid pulse
  input  wire [1:0] alt_on_i,      // alternate_function_on, pins 6,7
  input  wire       clk32k_i,      // 32 kHz clock for pin six
  input  wire       seq_out_i,     // sequencer output for pin seven
  input  wire [1:0] pin_i,         // pin levels, pins 6,7
  output wire [1:0] pin_o,         // pin output value
  output wire [1:0] pin_oe_o,      // pin output enable, high drives
  output wire [7:0] pullup_on_o,   // pull-up enables, all pins
  output wire [7:0] pulldown_on_o, // pull-down enables, all pins
  output wire [1:0] edge_pend_o,   // sticky edge pending flags
  output wire       alt_in6_o      // pin six alternate input, active
);

  // register state
  // both config bytes sit in one vector, indexed by pin
  reg  [15:0] cfg_q;      // both config registers, 8 bits each
  reg  [15:0] cfg_d;      // next config
  reg  [7:0]  pue_q;      // pull-up enables
  reg  [7:0]  pue_d;
  reg  [7:0]  pde_q;      // pull-down enables
  reg  [7:0]  pde_d;
  reg  [1:0]  pend_q;     // pending edge flags
  reg  [1:0]  pend_d;
  reg  [7:0]  rdata_q;    // read data
  reg  [7:0]  rdata_d;
  reg         rvalid_q;   // read answer pulse

  // pin side state
  // everything here but alt6_q is per pin, bit 0 for pin six
  wire [1:0]  flt_lvl;    // debounced levels
  reg  [1:0]  prev_q;     // debounced level one cycle back
  reg  [1:0]  in_mode;    // pin is a plain input
  reg  [1:0]  hit;        // qualifying edge this cycle
  reg  [1:0]  po_q;       // pin output value
  reg  [1:0]  po_d;
  reg  [1:0]  poe_q;      // pin output enable
  reg  [1:0]  poe_d;
  reg         alt6_q;     // qualified alternate input
  reg         alt6_d;

  // loop indices, one per combinational process so that no
  // variable is written from two processes
  integer i;              // mode decode loop
  integer j;              // edge qualification loop
  integer k;              // register write loop
  integer m;              // pin drive loop

  // config byte of pin n
  function [7:0] cfg_of;
    input [15:0] c;
    input integer n;
    begin
      cfg_of = c[n*8 +: 8];
    end
  endfunction

  // register address of pin n
  // pin index 0 is pin six, index 1 is pin seven
  function [7:0] cfg_addr;
    input integer n;
    begin
      if (n == 0) begin
        cfg_addr = `PG_ADDR_CFG6;
      end else begin
        cfg_addr = `PG_ADDR_CFG7;
      end
    end
  endfunction

  // plain input: alternate off and direction set to input
  function is_input;
    input [7:0] c;
    input       alt;
    begin
      is_input = ~alt & (c[`PG_DIR] == `PG_DIR_IN);
    end
  endfunction

  // config byte as read back: input pins show the filtered pad
  // level in the sampled bit instead of the stored one
  function [7:0] cfg_view;
    input [7:0] c;        // stored config byte
    input       inp;      // pin is a plain input
    input       lvl;      // filtered pad level
    begin
      cfg_view = c;
      if (inp) begin
        cfg_view[`PG_SMP] = lvl;
      end
    end
  endfunction

  // mode of each pin, used by filter, events, writes and reads
  // alternate use counts as neither input nor plain output
  // the mode is decoded once here and shared, so all users agree
  always @* begin
    for (i = 0; i < NPIN; i = i + 1) begin
      in_mode[i] = is_input(cfg_of(cfg_q, i), alt_on_i[i]);
    end
  end

  // one debounce filter per pin
  // counts run on the system clock, so the cycle parameters
  // must follow any change of clock rate
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      wire [1:0] sel;
      // output pins run unfiltered, the field is not used
      assign sel = in_mode[g] ?
        cfg_q[g*8+`PG_FLT_LO +: 2] : `PG_FLT_NONE;
      pgpio_filter #(
        .CW  (CW),
        .T8  (FLT8_CYC),
        .T16 (FLT16_CYC),
        .T32 (FLT32_CYC)
      ) u_flt (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .level_i   (pin_i[g]),
        .sel_i     (sel),
        .level_o   (flt_lvl[g])
      );
    end
  endgenerate

  // edge qualification after the filter; the filtered level is
  // compared with its value one cycle back, so with a debounce time set
  // a bouncing pad never reaches the pending flags
  always @* begin
    for (j = 0; j < NPIN; j = j + 1) begin
      // field 00 selects neither edge, so nothing fires
      // output and alternate pins are masked by the mode
      hit[j] = in_mode[j] & (
        (flt_lvl[j] & ~prev_q[j] & cfg_q[j*8+`PG_IRQ_RISE]) |
        (~flt_lvl[j] & prev_q[j] & cfg_q[j*8+`PG_IRQ_FALL]));
    end
  end

  // pending flags: a new edge wins over a clear in the same cycle,
  // so software never loses an event by clearing too late; the
  // cost is that a flag may read set again right after a clear
  always @* begin
    pend_d = pend_q;
    if (reg_wr_i && reg_addr_i == `PG_ADDR_PEND) begin
      pend_d = pend_q & ~reg_wdata_i[1:0];
    end
    pend_d = pend_d | hit;
  end

  // register writes and their side effects
  // the pull side effect looks at the mode before the write, so a
  // write that turns a pin into an input leaves the pulls alone;
  // a later write of the level bit is needed for that
  always @* begin
    cfg_d = cfg_q;
    pue_d = pue_q;
    pde_d = pde_q;
    if (reg_wr_i) begin
      // shared pull registers written whole
      if (reg_addr_i == `PG_ADDR_PUE) begin
        pue_d = reg_wdata_i;
      end
      if (reg_addr_i == `PG_ADDR_PDE) begin
        pde_d = reg_wdata_i;
      end
      for (k = 0; k < NPIN; k = k + 1) begin
        if (reg_addr_i == cfg_addr(k)) begin
          // whole byte first, then the input-only exceptions
          cfg_d[k*8 +: 8] = reg_wdata_i;
          if (in_mode[k]) begin
            // sampled bit keeps its stored value while input
            cfg_d[k*8+`PG_SMP] = cfg_q[k*8+`PG_SMP];
            // level bit picks which pull to switch on
            if (reg_wdata_i[`PG_LVL]) begin
              pde_d[`PG_PIN_BASE+k] = 1'h1;
            end else begin
              pue_d[`PG_PIN_BASE+k] = 1'h1;
            end
          end
        end
      end
    end
  end

  // read mux, unmapped addresses read as zero
  // output and alternate pins show the stored sampled bit, which
  // a write made while the pin was an input could not change
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `PG_ADDR_CFG6: begin
        rdata_d = cfg_view(cfg_of(cfg_q, 0), in_mode[0], flt_lvl[0]);
      end
      `PG_ADDR_CFG7: begin
        rdata_d = cfg_view(cfg_of(cfg_q, 1), in_mode[1], flt_lvl[1]);
      end
      `PG_ADDR_PUE: begin
        rdata_d = pue_q;
      end
      `PG_ADDR_PDE: begin
        rdata_d = pde_q;
      end
      `PG_ADDR_PEND: begin
        rdata_d = {6'h00, pend_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // pin drive, alternate use takes priority over the config
  // the drive is registered, so a config change reaches the pad
  // one cycle after the write and the pad never sees a glitch
  always @* begin
    for (m = 0; m < NPIN; m = m + 1) begin
      if (alt_on_i[m]) begin
        // alternate outputs always drive push-pull, active high
        poe_d[m] = 1'h1;
        if (m == 0) begin
          po_d[m] = clk32k_i;
        end else begin
          po_d[m] = seq_out_i;
        end
      end else if (in_mode[m]) begin
        // input: drive bit and level bit play no part
        poe_d[m] = 1'h0;
        po_d[m]  = 1'h0;
      end else if (cfg_q[m*8+`PG_DRV] == `PG_DRV_PP) begin
        // push-pull follows the level bit
        poe_d[m] = 1'h1;
        po_d[m]  = cfg_q[m*8+`PG_LVL];
      end else begin
        // open-drain: only ever pulls low, high is released
        poe_d[m] = ~cfg_q[m*8+`PG_LVL];
        po_d[m]  = 1'h0;
      end
    end
  end

  // pin six as alternate input: direction picks polarity
  // it reads the unfiltered pad, since alternate use bypasses the
  // debounce; a slow alternate source must be clean on the board
  always @* begin
    alt6_d = 1'h0;
    if (alt_on_i[0]) begin
      // direction 0 means the signal is active low
      alt6_d = cfg_q[`PG_DIR] ? flt_lvl[0] : ~flt_lvl[0];
    end
  end

  // all state, frozen while the clock enable is low
  // reset leaves both pins as open-drain outputs pulling low,
  // with every pull off and no event pending, so a pad held high
  // by the board gives no false edge once it becomes an input
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q    <= {`PG_CFG7_RST, `PG_CFG6_RST};
      pue_q    <= `PG_PUE_RST;
      pde_q    <= `PG_PDE_RST;
      pend_q   <= `PG_PEND_RST;
      prev_q   <= 2'h0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'h0;
      po_q     <= 2'h0;
      poe_q    <= 2'h0;
      alt6_q   <= 1'h0;
    end else if (ce_i) begin
      cfg_q    <= cfg_d;
      pue_q    <= pue_d;
      pde_q    <= pde_d;
      pend_q   <= pend_d;
      prev_q   <= flt_lvl;
      rvalid_q <= reg_rd_i;
      po_q     <= po_d;
      poe_q    <= poe_d;
      alt6_q   <= alt6_d;
      // read data only changes on a read, so it holds for the host
      if (reg_rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // outputs, all from flip-flops
  // pull enables of pins zero to five pass through untouched
  assign reg_rdata_o   = rdata_q;
  assign reg_rvalid_o  = rvalid_q;
  assign pin_o         = po_q;
  assign pin_oe_o      = poe_q;
  assign pullup_on_o   = pue_q;
  assign pulldown_on_o = pde_q;
  assign edge_pend_o   = pend_q;
  assign alt_in6_o     = alt6_q;

endmodule

`default_nettype wire

// File: tb/pgpio_pin_cfg_sva.sv
// port-level assertion checker for the pin config block
`default_nettype none

module pgpio_pin_cfg_sva (
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  input wire logic       ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic [1:0] alt_on_i,
  input wire logic       clk32k_i,
  input wire logic       seq_out_i,
  input wire logic [1:0] pin_i,
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe_o,
  input wire logic [7:0] pullup_on_o,
  input wire logic [7:0] pulldown_on_o,
  input wire logic [1:0] edge_pend_o,
  input wire logic       alt_in6_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // strobes that the block really takes
  wire logic wr_go = reg_wr_i && ce_i;
  wire logic rd_go = reg_rd_i && ce_i;

  AST_RD_ANSWER: assert property (rd_go |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  // read data holds between reads
  AST_RD_QUIET: assert property (
    ce_i && !reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("read answer without a read");
  AST_UNMAPPED: assert property (rd_go && (reg_addr_i < 8'h76 ||
    (reg_addr_i > 8'h79 && reg_addr_i != 8'hF0)) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_PUE_WR: assert property (
    wr_go && reg_addr_i == 8'h78 |=> pullup_on_o == $past(reg_wdata_i))
    else $error("pull-up enables not written");
  AST_PDE_WR: assert property (
    wr_go && reg_addr_i == 8'h79 |=> pulldown_on_o == $past(reg_wdata_i))
    else $error("pull-down enables not written");
  AST_PEND_STICKY: assert property (edge_pend_o[0] &&
    !(wr_go && reg_addr_i == 8'hF0 && reg_wdata_i[0]) |=> edge_pend_o[0])
    else $error("pending flag dropped without clear");
  // a driven pin six pad never reports a pin event
  AST_PEND_DRIVEN: assert property (
    $rose(edge_pend_o[0]) |-> !$past(pin_oe_o[0]))
    else $error("pending flag on a driven pin");
  AST_ALT7_OUT: assert property (alt_on_i[1] && $past(alt_on_i[1]) &&
    ce_i && $stable(seq_out_i) |=>
    pin_oe_o[1] && pin_o[1] == $past(seq_out_i))
    else $error("pin seven alternate drive wrong");
  AST_ALT6_OUT: assert property (alt_on_i[0] && $past(alt_on_i[0]) &&
    ce_i && $stable(clk32k_i) |=> pin_oe_o[0] && pin_o[0] == $past(clk32k_i))
    else $error("pin six alternate drive wrong");

  COV_READ: cover property (rd_go ##1 reg_rvalid_o);
  COV_PEND: cover property ($rose(edge_pend_o[0]));
  COV_ALT7: cover property (alt_on_i[1] ##2 pin_oe_o[1]);
endmodule

bind pgpio_pin_cfg pgpio_pin_cfg_sva i_pgpio_pin_cfg_sva (.*);
`default_nettype wire

// File: tb/pgpio_board.sv
// board model for pins six and seven: drivers, pulls, floating pad
`default_nettype none

module pgpio_board (
  input  wire logic       clk_sys_i,
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe_o,
  input  wire logic [1:0] pu_i,
  input  wire logic [1:0] pd_i,
  input  wire logic [1:0] ext_en_i,
  input  wire logic [1:0] ext_val_i,
  output var  logic [1:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] float_q = 2'b01; // undriven pad wanders, never a stale level
  always @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end
  // device drive wins, then board driver, then pulls, else wander
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (pin_oe_o[k]) pin_i[k] = pin_o[k];
      else if (ext_en_i[k]) pin_i[k] = ext_val_i[k];
      else if (pu_i[k]) pin_i[k] = 1'b1;
      else if (pd_i[k]) pin_i[k] = 1'b0;
      else pin_i[k] = float_q[k];
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the pin config block
`default_nettype none
`include "pgpio_defs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i, arst_n_i, ce_i, reg_wr_i, reg_rd_i;
  logic       clk32k_i, seq_out_i, reg_rvalid_o, alt_in6_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pullup_on_o;
  logic [7:0] pulldown_on_o, v;
  logic [1:0] alt_on_i, pin_i, pin_o, pin_oe_o, edge_pend_o, ext_en, ext_val;
  logic [7:0] exp_q[$]; // read answers still owed
  int         error_cnt, total_checks, t;

  // short debounce counts keep the run brief
  pgpio_pin_cfg #(.FLT8_CYC(8), .FLT16_CYC(16), .FLT32_CYC(32))
    i_pgpio_pin_cfg (.*);
  pgpio_board i_pgpio_board (.pu_i(pullup_on_o[7:6]),
    .pd_i(pulldown_on_o[7:6]), .ext_en_i(ext_en), .ext_val_i(ext_val), .*);

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp(input string nm, input logic [7:0] e, s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // one-cycle write strobe, released on the edge that takes it
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  // the expected answer is noted before the strobe goes out
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // answers are matched in order against the owed notes
  always @(negedge clk_sys_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) cmp("stray read", 8'h00, 8'hFF);
      else cmp("read data", exp_q.pop_front(), reg_rdata_o);
    end
  end

  // hang guard
  initial begin
    cyc(5000);
    cmp("run length", 8'h00, 8'hFF);
    end_sim();
  end

  initial begin
    {arst_n_i, reg_wr_i, reg_rd_i, clk32k_i, seq_out_i} = '0;
    ce_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    alt_on_i = 2'b00;
    ext_en = 2'b11;
    ext_val = 2'b00;
    void'($urandom(61090));
    cyc(20);
    arst_n_i <= 1'b1;
    // reset contents, unmapped place, idle drive
    rd(`PG_ADDR_CFG6, 8'h00);
    rd(`PG_ADDR_CFG7, 8'h00);
    rd(`PG_ADDR_PUE, 8'h00);
    rd(`PG_ADDR_PDE, 8'h00);
    rd(8'h10, 8'h00);
    @(negedge clk_sys_i);
    cmp("pin oe", 8'h03, {6'h0, pin_oe_o});
    cmp("pin out", 8'h00, {6'h0, pin_o});
    $display("test reset done");
    // output modes on pin six, noise in ignored fields, pad floats
    ext_en[0] <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[3] = i[1];
      v[1] = 1'b0;
      v[0] = i[0];
      wr(`PG_ADDR_CFG6, v);
      cyc(2);
      @(negedge clk_sys_i);
      cmp("pin6 oe", {7'h0, i[0] | ~i[1]}, {7'h0, pin_oe_o[0]});
      if (i != 2) cmp("pin6 out", {7'h0, i[1]}, {7'h0, pin_o[0]});
    end
    rd(`PG_ADDR_PEND, 8'h00);
    ext_en[0] <= 1'b1;
    $display("test output done");
    // shared pull registers
    v = 8'($urandom);
    wr(`PG_ADDR_PUE, v);
    wr(`PG_ADDR_PDE, ~v);
    // clock enable low: a write strobe must leave no trace
    ce_i <= 1'b0;
    wr(`PG_ADDR_PUE, ~v);
    ce_i <= 1'b1;
    rd(`PG_ADDR_PUE, v);
    rd(`PG_ADDR_PDE, ~v);
    @(negedge clk_sys_i);
    cmp("pullups", v, pullup_on_o);
    cmp("pulldowns", ~v, pulldown_on_o);
    // pull side effects of level writes on input pin seven
    wr(`PG_ADDR_PUE, 8'h00);
    wr(`PG_ADDR_PDE, 8'h00);
    wr(`PG_ADDR_CFG7, 8'h02);
    wr(`PG_ADDR_CFG7, 8'h06);
    rd(`PG_ADDR_CFG7, 8'h02);
    rd(`PG_ADDR_PUE, 8'h80);
    wr(`PG_ADDR_CFG7, 8'h0A);
    rd(`PG_ADDR_CFG7, 8'h0A);
    rd(`PG_ADDR_PDE, 8'h80);
    $display("test pulls done");
    // every edge select on pin six, pin seven masked and toggling
    for (int s = 0; s < 4; s++) begin
      wr(`PG_ADDR_CFG6, {2'b00, s[1:0], 4'b0011});
      cyc(4);
      wr(`PG_ADDR_PEND, 8'h03);
      ext_val <= 2'b11;
      cyc(4);
      rd(`PG_ADDR_PEND, {7'h0, s[1]});
      wr(`PG_ADDR_PEND, 8'h03);
      ext_val <= 2'b00;
      cyc(4);
      rd(`PG_ADDR_PEND, {7'h0, s[0]});
    end
    $display("test edges done");
    // each debounce length: short glitch dropped, long level taken
    for (int f = 1; f < 4; f++) begin
      t = 8 << (f - 1);
      wr(`PG_ADDR_CFG6, {f[1:0], 6'b110010});
      cyc(t + 4);
      wr(`PG_ADDR_PEND, 8'h03);
      ext_val[0] <= 1'b1;
      cyc(t / 2);
      ext_val[0] <= 1'b0;
      cyc(t + 4);
      rd(`PG_ADDR_PEND, 8'h00);
      ext_val[0] <= 1'b1;
      cyc(t + 4);
      rd(`PG_ADDR_PEND, 8'h01);
      rd(`PG_ADDR_CFG6, {f[1:0], 6'b110110});
      ext_val[0] <= 1'b0;
      cyc(t + 4);
    end
    $display("test debounce done");
    // alternate use: pulls cleared first, fields ignored
    wr(`PG_ADDR_PUE, 8'h00);
    wr(`PG_ADDR_PDE, 8'h00);
    wr(`PG_ADDR_CFG6, 8'h36);
    wr(`PG_ADDR_PEND, 8'h03);
    alt_on_i <= 2'b11;
    ext_en <= 2'b00;
    for (int i = 0; i < 40; i++) begin
      {clk32k_i, seq_out_i} <= 2'($urandom);
      cyc(1);
    end
    rd(`PG_ADDR_CFG6, 8'h32);
    clk32k_i <= 1'b1;
    cyc(4);
    @(negedge clk_sys_i);
    cmp("alt input", 8'h01, {7'h0, alt_in6_o});
    wr(`PG_ADDR_CFG6, 8'h30);
    cyc(3);
    @(negedge clk_sys_i);
    cmp("alt input", 8'h00, {7'h0, alt_in6_o});
    rd(`PG_ADDR_PEND, 8'h00);
    cyc(4);
    cmp("reads owed", 8'h00, 8'(exp_q.size()));
    $display("test alternate done");
    end_sim();
  end
endmodule
`default_nettype wire
